// ===== interrupt_stack_sequencer.sv
// Interrupt acceptance, entry and return sequencing, stack top pointer and indirect pointers.
// Assumes op codes, events and register writes arrive on ref_clk from the core's own logic.
//
// Operation
// - Stack grows downward; every push lowers the stack top pointer.
// - Data push lowers pointer by one; call or interrupt entry by two.
// - Data pop raises pointer by one; return or handler return by two.
// - Pointer is high and low I/O bytes, read-write, reset to top of RAM.
// - Core runs on the undivided selected clock, no internal divider.
// - Operands read, operated and written back within one clock cycle.
// - A source is taken only with own enable and global enable set.
// - Lowest vector wins among pending requests; request zero ranks first.
// - Accepting an interrupt clears the global enable.
// - Return from handler sets the global enable.
// - Vectoring clears the source flag; writing one also clears it.
// - Flag events while disabled are held until serviced or cleared.
// - Level sources request only while their condition is present.
// - After return one instruction runs before another interrupt.
// - Status register is never saved or restored automatically.
// - Disable instruction acts at once, blocking a same-cycle request.
// - After enable instruction the next instruction runs first.
// - Entry takes four cycles, pushing the program counter.
// - A multi-cycle instruction completes before entry begins.
// - Wake from sleep lengthens entry by four cycles.
// - Return takes four cycles, pops two bytes, sets global enable.
// - Top six registers form three 16-bit pointers with four modes.
// - Pairs 26/27, 28/29, 30/31, lower register is low byte.
// - Global enable is status bit 7.
`include "iss_regs.svh"

module interrupt_stack_sequencer
	import iss_pkg::*;
#(
	parameter int           N_FLAG   = 4,
	parameter int           N_LEVEL  = 2,
	parameter int           SP_W     = 16,
	parameter logic [15:0]  RAM_TOP  = 16'h02ff
) (
	input  wire logic                      ref_clk,
	input  wire logic                      arst_n,
	input  wire logic                      instr_done,
	input  wire logic [2:0]                instr_op,
	input  wire logic                      sleeping,
	input  wire logic [N_FLAG-1:0]         flag_evt,
	input  wire logic [N_FLAG-1:0]         flag_w1c,
	input  wire logic [N_LEVEL-1:0]        level_req,
	input  wire logic [N_FLAG+N_LEVEL-1:0] src_en,
	input  wire logic                      alu_we,
	input  wire logic [6:0]                alu_flags,
	input  wire logic [5:0]                io_addr,
	input  wire logic                      io_wr,
	input  wire logic                      io_rd,
	input  wire logic [7:0]                io_wdata,
	input  wire logic                      gpr_wr,
	input  wire logic [4:0]                gpr_idx,
	input  wire logic [7:0]                gpr_wdata,
	input  wire logic                      ptr_use,
	input  wire logic [1:0]                ptr_sel,
	input  wire logic [1:0]                ptr_mode,
	input  wire logic [5:0]                ptr_disp,
	output logic      [7:0]                io_rdata_q,
	output logic      [SP_W-1:0]           sp_q,
	output logic      [7:0]                status_register_q,
	output logic                           core_hold_q,
	output logic                           vec_go_q,
	output logic      [7:0]                vec_idx_q,
	output logic                           ret_done_q,
	output logic      [15:0]               ptr_addr_q
);

	localparam int N_SRC = N_FLAG + N_LEVEL;

	if (SP_W != 8 && SP_W != 16) begin : g_bad_sp
		$error("stack pointer width must be 8 or 16");
	end
	if (N_SRC > 255 || N_LEVEL < 1) begin : g_bad_src
		$error("unsupported source count");
	end

	// ============================================================
	// Request gathering and priority
	function automatic logic [7:0] first_set(input logic [N_SRC-1:0] v);
		logic [7:0] idx;
		idx = 8'h00;
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 8'(i);
			end
		end
		return idx;
	endfunction : first_set

	logic [N_FLAG-1:0] flag_q;
	logic [N_FLAG-1:0] flag_ack;
	logic [N_SRC-1:0]  req;
	logic [7:0]        win_idx;
	logic              gie;
	logic              take;
	iss_state_e        st_q;
	logic [3:0]        cnt_q;
	iss_op_e           op;

	assign op = iss_op_e'(instr_op);
	assign gie = status_register_q[`ISS_GIE_BIT];
	assign req = {level_req, flag_q} & src_en;
	assign win_idx = first_set(req);
	// Boundaries only; the enable instruction's own boundary sees the old clear bit.
	assign take = instr_done && (st_q == ISS_ST_RUN) && gie && (|req)
		&& (op != ISS_OP_CLI) && (op != ISS_OP_RETURN_FROM_HANDLER);

	for (genvar i = 0; i < N_FLAG; i++) begin : g_ack
		assign flag_ack[i] = take && (win_idx == 8'(i));
	end

	iss_flag_bank #(
		.N_FLAG (N_FLAG)
	) u_flags (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.evt_set (flag_evt),
		.sw_clr  (flag_w1c),
		.hw_ack  (flag_ack),
		.flag_q  (flag_q)
	);

	// ============================================================
	// Entry and return sequencer; all timing is on the undivided ref_clk.
	logic seq_end;
	assign seq_end = (st_q != ISS_ST_RUN) && (cnt_q == 4'h1);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ISS_ST_RUN;
			cnt_q <= 4'h0;
		end else begin
			case (st_q)
				ISS_ST_RUN: begin
					if (take) begin
						st_q <= ISS_ST_ENTRY;
						cnt_q <= sleeping ? 4'(`ISS_ENTRY_CYC + `ISS_SLEEP_EXTRA - 1)
							: 4'(`ISS_ENTRY_CYC - 1);
					end else if (instr_done && op == ISS_OP_RETURN_FROM_HANDLER) begin
						st_q <= ISS_ST_RET;
						cnt_q <= 4'(`ISS_RETURN_CYC - 1);
					end
				end
				ISS_ST_ENTRY, ISS_ST_RET: begin
					cnt_q <= cnt_q - 4'h1;
					if (seq_end) begin
						st_q <= ISS_ST_RUN;
					end
				end
				default: begin
					st_q <= ISS_ST_RUN;
					cnt_q <= 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			core_hold_q <= 1'b0;
			vec_go_q <= 1'b0;
			vec_idx_q <= 8'h00;
			ret_done_q <= 1'b0;
		end else begin
			core_hold_q <= (take || (instr_done && op == ISS_OP_RETURN_FROM_HANDLER && st_q == ISS_ST_RUN)
				|| (st_q != ISS_ST_RUN)) && !seq_end;
			vec_go_q <= seq_end && (st_q == ISS_ST_ENTRY);
			ret_done_q <= seq_end && (st_q == ISS_ST_RET);
			if (take) begin
				vec_idx_q <= win_idx;
			end
		end
	end

	// ============================================================
	// Status register: only the global enable is touched by sequencing.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			status_register_q <= `ISS_STATUS_REGISTER_RST;
		end else begin
			if (alu_we) begin
				status_register_q[6:0] <= alu_flags;
			end
			if (io_wr && io_addr == `ISS_OFF_STATUS_REGISTER) begin
				status_register_q <= io_wdata;
			end
			if (instr_done && st_q == ISS_ST_RUN && op == ISS_OP_SEI) begin
				status_register_q[`ISS_GIE_BIT] <= 1'b1;
			end
			if (instr_done && st_q == ISS_ST_RUN && op == ISS_OP_CLI) begin
				status_register_q[`ISS_GIE_BIT] <= 1'b0;
			end
			if (take) begin
				status_register_q[`ISS_GIE_BIT] <= 1'b0;
			end
			if (seq_end && st_q == ISS_ST_RET) begin
				status_register_q[`ISS_GIE_BIT] <= 1'b1;
			end
		end
	end

	// ============================================================
	// Stack top pointer
	logic [SP_W-1:0] sp_delta;
	always_comb begin
		sp_delta = '0;
		if (instr_done && st_q == ISS_ST_RUN) begin
			case (op)
				ISS_OP_PUSH: sp_delta = '1;
				ISS_OP_CALL: sp_delta = SP_W'(-2);
				ISS_OP_POP: sp_delta = SP_W'(1);
				ISS_OP_RET, ISS_OP_RETURN_FROM_HANDLER: sp_delta = SP_W'(2);
				default: sp_delta = '0;
			endcase
		end
		if (take) begin
			sp_delta = sp_delta - SP_W'(2);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sp_q <= RAM_TOP[SP_W-1:0];
		end else if (io_wr && io_addr == `ISS_OFF_SPL) begin
			sp_q[7:0] <= io_wdata;
		end else if (io_wr && io_addr == `ISS_OFF_SPH && SP_W > 8) begin
			sp_q[SP_W-1:SP_W-8] <= io_wdata;
		end else begin
			sp_q <= sp_q + sp_delta;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			io_rdata_q <= 8'h00;
		end else if (io_rd) begin
			case (io_addr)
				`ISS_OFF_SPL: io_rdata_q <= sp_q[7:0];
				`ISS_OFF_SPH: io_rdata_q <= (SP_W > 8) ? sp_q[SP_W-1:SP_W-8] : 8'h00;
				`ISS_OFF_STATUS_REGISTER: io_rdata_q <= status_register_q;
				default: io_rdata_q <= 8'h00;
			endcase
		end
	end

	// ============================================================
	// Indirect pointers held in the top six registers
	logic [15:0] ptr_q [3];
	logic [1:0]  psel;
	assign psel = (ptr_sel > 2'h2) ? 2'h2 : ptr_sel;

	for (genvar p = 0; p < 3; p++) begin : g_ptr
		always_ff @(posedge ref_clk or negedge arst_n) begin
			if (!arst_n) begin
				ptr_q[p] <= 16'h0000;
			end else if (gpr_wr && (gpr_idx >> 1) == ((`ISS_PTR_BASE >> 1) + 5'(p))) begin
				if (gpr_idx[0]) begin
					ptr_q[p][15:8] <= gpr_wdata;
				end else begin
					ptr_q[p][7:0] <= gpr_wdata;
				end
			end else if (ptr_use && psel == 2'(p)) begin
				if (ptr_mode == ISS_PM_POSTINC) begin
					ptr_q[p] <= ptr_q[p] + 16'h0001;
				end else if (ptr_mode == ISS_PM_PREDEC) begin
					ptr_q[p] <= ptr_q[p] - 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ptr_addr_q <= 16'h0000;
		end else if (ptr_use) begin
			case (ptr_mode)
				ISS_PM_PREDEC: ptr_addr_q <= ptr_q[psel] - 16'h0001;
				ISS_PM_DISP: ptr_addr_q <= ptr_q[psel] + {10'h000, ptr_disp};
				default: ptr_addr_q <= ptr_q[psel];
			endcase
		end
	end

	// ============================================================
	// Checks
	property p_entry_time;
		@(posedge ref_clk) disable iff (!arst_n)
		(take && !sleeping) |=> !vec_go_q[*3] ##1 vec_go_q;
	endproperty
	a_entry_time: assert property (p_entry_time) else $error("entry not four cycles");

	property p_sleep_time;
		@(posedge ref_clk) disable iff (!arst_n)
		(take && sleeping) |=> !vec_go_q[*7] ##1 vec_go_q;
	endproperty
	a_sleep_time: assert property (p_sleep_time) else $error("wake entry not eight cycles");

	property p_gie_off;
		@(posedge ref_clk) disable iff (!arst_n)
		take |=> !status_register_q[7];
	endproperty
	a_gie_off: assert property (p_gie_off) else $error("enable not cleared on entry");

	property p_ret;
		@(posedge ref_clk) disable iff (!arst_n)
		(instr_done && op == ISS_OP_RETURN_FROM_HANDLER && st_q == ISS_ST_RUN && !io_wr)
			|=> (sp_q == $past(sp_q) + SP_W'(2)) ##3 ret_done_q && status_register_q[7];
	endproperty
	a_ret: assert property (p_ret) else $error("return sequence wrong");

	property p_cli;
		@(posedge ref_clk) disable iff (!arst_n)
		(instr_done && op == ISS_OP_CLI && st_q == ISS_ST_RUN)
			|=> !core_hold_q && !status_register_q[7];
	endproperty
	a_cli: assert property (p_cli) else $error("taken during disable");

	property p_push;
		@(posedge ref_clk) disable iff (!arst_n)
		(instr_done && op == ISS_OP_PUSH && st_q == ISS_ST_RUN && !take && !io_wr)
			|=> sp_q == $past(sp_q) - SP_W'(1);
	endproperty
	a_push: assert property (p_push) else $error("push did not lower pointer");

	property p_prio;
		@(posedge ref_clk) disable iff (!arst_n)
		(take && req[0] && !sleeping) |-> ##4 vec_go_q && vec_idx_q == 8'h00;
	endproperty
	a_prio: assert property (p_prio) else $error("request zero not first");

	property p_enable;
		@(posedge ref_clk) disable iff (!arst_n)
		(instr_done && st_q == ISS_ST_RUN && op != ISS_OP_RETURN_FROM_HANDLER && !status_register_q[7])
			|=> !core_hold_q;
	endproperty
	a_enable: assert property (p_enable) else $error("taken while disabled");

	property p_no_req;
		@(posedge ref_clk) disable iff (!arst_n)
		(instr_done && st_q == ISS_ST_RUN && op != ISS_OP_RETURN_FROM_HANDLER && !(|({level_req, flag_q} & src_en)))
			|=> !core_hold_q;
	endproperty
	a_no_req: assert property (p_no_req) else $error("taken without enabled request");

	property p_busy;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_q != ISS_ST_RUN) |-> !take && core_hold_q;
	endproperty
	a_busy: assert property (p_busy) else $error("taken during sequence");

	c_take: cover property (@(posedge ref_clk) disable iff (!arst_n) take ##4 vec_go_q);
	c_ret: cover property (@(posedge ref_clk) disable iff (!arst_n) ret_done_q);
	c_sleep: cover property (@(posedge ref_clk) disable iff (!arst_n) take && sleeping);

endmodule : interrupt_stack_sequencer

// ===== iss_core_model.sv
// Model of the core's instruction sequencer as seen by the interrupt and stack sequencer.
// Assumes the bench raises issue for one ref_clk cycle per instruction.
module iss_core_model (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       core_hold_q,
	input  wire logic       slow,
	input  wire logic       issue,
	input  wire logic [2:0] issue_op,
	output logic            instr_done,
	output logic      [2:0] instr_op
);
	logic       issue_q;
	logic [2:0] op_q;
	logic       fire;

	assign fire = slow ? issue_q : issue;

	// ============================================================
	// Completion reporting
	// A stalled core cannot complete, so an issue during core_hold_q is lost.
	// The op code toggles outside completions so that nothing relies on a stale value.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			issue_q    <= 1'b0;
			op_q       <= 3'h0;
			instr_done <= 1'b0;
			instr_op   <= 3'h0;
		end else begin
			issue_q    <= issue;
			op_q       <= issue_op;
			instr_done <= fire & ~core_hold_q;
			instr_op   <= fire ? (slow ? op_q : issue_op) : ~instr_op;
		end
	end
endmodule : iss_core_model

// ===== iss_flag_bank.sv
// Sticky pending flags of the latched-type interrupt sources.
// Assumes event, clear and acknowledge inputs come from logic on ref_clk.
module iss_flag_bank
	import iss_pkg::*;
#(
	parameter int N_FLAG = 4
) (
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	input  wire logic [N_FLAG-1:0] evt_set,
	input  wire logic [N_FLAG-1:0] sw_clr,
	input  wire logic [N_FLAG-1:0] hw_ack,
	output logic      [N_FLAG-1:0] flag_q
);

	if (N_FLAG < 1) begin : g_bad_count
		$error("iss_flag_bank needs at least one flag");
	end

	// ============================================================
	// One flag per source; a new event beats a clear in the same cycle.
	for (genvar i = 0; i < N_FLAG; i++) begin : g_flag
		always_ff @(posedge ref_clk or negedge arst_n) begin
			if (!arst_n) begin
				flag_q[i] <= 1'b0;
			end else if (evt_set[i]) begin
				flag_q[i] <= 1'b1;
			end else if (sw_clr[i] || hw_ack[i]) begin
				flag_q[i] <= 1'b0;
			end
		end
	end

	property p_flag_hold;
		@(posedge ref_clk) disable iff (!arst_n)
		(flag_q[0] && !sw_clr[0] && !hw_ack[0]) |=> flag_q[0];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("pending flag lost");

	property p_flag_set;
		@(posedge ref_clk) disable iff (!arst_n)
		evt_set[0] |=> flag_q[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

endmodule : iss_flag_bank

// ===== iss_pkg.sv
// Types shared by the interrupt and stack sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package iss_pkg;

	// ============================================================
	// Instruction completion codes from the instruction sequencer
	typedef enum logic [2:0] {
		ISS_OP_NONE = 3'h0,
		ISS_OP_PUSH = 3'h1,
		ISS_OP_POP  = 3'h2,
		ISS_OP_CALL = 3'h3,
		ISS_OP_RET  = 3'h4,
		ISS_OP_RETURN_FROM_HANDLER = 3'h5,
		ISS_OP_SEI  = 3'h6,
		ISS_OP_CLI  = 3'h7
	} iss_op_e;

	// ============================================================
	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		ISS_ST_RUN   = 3'b001,
		ISS_ST_ENTRY = 3'b010,
		ISS_ST_RET   = 3'b100
	} iss_state_e;

	// ============================================================
	// Pointer addressing modes
	typedef enum logic [1:0] {
		ISS_PM_PLAIN = 2'h0,
		ISS_PM_POSTINC = 2'h1,
		ISS_PM_PREDEC = 2'h2,
		ISS_PM_DISP = 2'h3
	} iss_pmode_e;

endpackage : iss_pkg

// ===== iss_regs.svh
// Offsets, field positions, reset values and cycle counts of the interrupt and stack sequencer.
// Assumes it is included by its bare name from files that need these constants.
`ifndef ISS_REGS_SVH
`define ISS_REGS_SVH

// ============================================================
// I/O space offsets
`define ISS_OFF_SPL       6'h3d
`define ISS_OFF_SPH       6'h3e
`define ISS_OFF_STATUS_REGISTER      6'h3f

// ============================================================
// Fields and reset values
`define ISS_GIE_BIT       7
`define ISS_STATUS_REGISTER_RST      8'h00
`define ISS_PTR_BASE      5'h1a

// ============================================================
// Timing in ref_clk cycles
`define ISS_ENTRY_CYC     4
`define ISS_SLEEP_EXTRA   4
`define ISS_RETURN_CYC    4

`endif

// ===== tb.sv
// Self-checking bench of the interrupt and stack sequencer.
// Assumes the design files and iss_core_model are compiled before it.
module tb
	import iss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        ref_clk = 0, arst_n = 0, sleeping = 0, slow = 0, issue = 0;
	logic        io_wr = 0, io_rd = 0, gpr_wr = 0, ptr_use = 0;
	logic [2:0]  issue_op = 0;
	logic [3:0]  flag_evt = 0, flag_w1c = 0;
	logic [5:0]  src_en = 0, io_addr = 0, ptr_disp = 0;
	logic [7:0]  io_wdata = 0, gpr_wdata = 0, rd, io_rdata_q, status_register_q, vec_idx_q;
	logic [4:0]  gpr_idx = 0;
	logic [1:0]  ptr_mode = 0, level_req = 0, ptr_sel = 0;
	logic        alu_we = 0;
	logic [6:0]  alu_flags = 0;
	logic [15:0] sp_q, ptr_addr_q, exp;
	logic [2:0]  instr_op;
	logic        instr_done, core_hold_q, vec_go_q, ret_done_q;
	int          n_mismatch = 0, compares = 0, n, nh;
	logic [2:0]  ops[4] = '{3'h1, 3'h2, 3'h3, 3'h4};
	logic [15:0] dlt[4] = '{16'hffff, 16'h0001, 16'hfffe, 16'h0002};
	logic [15:0] pexp[4] = '{16'h0110, 16'h0110, 16'h0110, 16'h0115};

	always #25 ref_clk = ~ref_clk;

	iss_core_model i_iss_core_model (.ref_clk(ref_clk), .arst_n(arst_n),
		.core_hold_q(core_hold_q), .slow(slow), .issue(issue), .issue_op(issue_op),
		.instr_done(instr_done), .instr_op(instr_op));

	interrupt_stack_sequencer i_interrupt_stack_sequencer (.ref_clk(ref_clk), .arst_n(arst_n),
		.instr_done(instr_done), .instr_op(instr_op), .sleeping(sleeping),
		.flag_evt(flag_evt), .flag_w1c(flag_w1c), .level_req(level_req), .src_en(src_en),
		.alu_we(alu_we), .alu_flags(alu_flags), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd),
		.io_wdata(io_wdata), .gpr_wr(gpr_wr), .gpr_idx(gpr_idx), .gpr_wdata(gpr_wdata),
		.ptr_use(ptr_use), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode), .ptr_disp(ptr_disp),
		.io_rdata_q(io_rdata_q), .sp_q(sp_q), .status_register_q(status_register_q), .core_hold_q(core_hold_q),
		.vec_go_q(vec_go_q), .vec_idx_q(vec_idx_q), .ret_done_q(ret_done_q),
		.ptr_addr_q(ptr_addr_q));

	task stop_test;
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	task chk(input string what, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task do_op(input logic [2:0] op);
		@(posedge ref_clk);
		issue    <= 1'b1;
		issue_op <= op;
		@(posedge ref_clk);
		issue    <= 1'b0;
	endtask : do_op

	task io_write(input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		io_wr    <= 1'b1;
		io_addr  <= a;
		io_wdata <= d;
		@(posedge ref_clk);
		io_wr    <= 1'b0;
	endtask : io_write

	task io_read(input logic [5:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		io_rd   <= 1'b1;
		io_addr <= a;
		@(posedge ref_clk);
		io_rd   <= 1'b0;
		@(posedge ref_clk);
		#1;
		d = io_rdata_q;
	endtask : io_read

	task gpr(input logic [4:0] i, input logic [7:0] d);
		@(posedge ref_clk);
		gpr_wr    <= 1'b1;
		gpr_idx   <= i;
		gpr_wdata <= d;
		@(posedge ref_clk);
		gpr_wr    <= 1'b0;
	endtask : gpr

	task ptr_step(input logic [1:0] s, input logic [1:0] m);
		@(posedge ref_clk);
		ptr_use  <= 1'b1;
		ptr_sel  <= s;
		ptr_mode <= m;
		ptr_disp <= 6'h05;
		@(posedge ref_clk);
		ptr_use  <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask : ptr_step

	task pulse_flag(input logic [3:0] b);
		@(posedge ref_clk);
		flag_evt <= b;
		@(posedge ref_clk);
		flag_evt <= 4'h0;
	endtask : pulse_flag

	// Counts edges until the pulse shows; zero means it never came within lim.
	// The stall cycles seen before the pulse are counted in nh.
	task wait_pulse(input int lim, input bit ret, output int k);
		k  = 0;
		nh = 0;
		for (int j = 1; j <= lim; j++) begin
			@(posedge ref_clk);
			#1;
			if ((ret ? ret_done_q : vec_go_q) === 1'b1) begin
				k = j;
				return;
			end
			if (core_hold_q === 1'b1)
				nh++;
		end
	endtask : wait_pulse

	task expect_pulse(input string what, input bit ret, input int e);
		wait_pulse(20, ret, n);
		chk(what, e[15:0], n[15:0]);
		chk("stall cycles", e[15:0] - 16'h0001, nh[15:0]);
		if (n == 0)
			stop_test();
	endtask : expect_pulse

	initial begin
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		src_en <= 6'h3f;
		#1;
		chk("sp reset", 16'h02ff, sp_q);
		chk("status_register reset", 16'h0000, {8'h00, status_register_q});
		$display("test reset done");
		slow <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			exp = sp_q + dlt[i];
			do_op(ops[i]);
			repeat (4) @(posedge ref_clk);
			#1;
			chk("sp after stack op", exp, sp_q);
		end
		slow <= 1'b0;
		$display("test stack table done");
		io_write(6'h3d, 8'h80);
		io_write(6'h3e, 8'h01);
		#1;
		chk("sp after io writes", 16'h0180, sp_q);
		io_read(6'h3d, rd);
		chk("low byte read", 16'h0080, {8'h00, rd});
		io_read(6'h3e, rd);
		chk("high byte read", 16'h0001, {8'h00, rd});
		io_read(6'h10, rd);
		chk("unmapped read", 16'h0000, {8'h00, rd});
		$display("test io done");
		gpr(5'h1c, 8'h10);
		gpr(5'h1d, 8'h01);
		gpr(5'h1a, 8'h78);
		gpr(5'h1b, 8'h56);
		gpr(5'h1e, 8'h34);
		gpr(5'h1f, 8'h12);
		for (int i = 0; i < 4; i++) begin
			ptr_step(2'h1, i[1:0]);
			chk("pointer address", pexp[i], ptr_addr_q);
		end
		ptr_step(2'h0, 2'h0);
		chk("first pointer", 16'h5678, ptr_addr_q);
		ptr_step(2'h3, 2'h0);
		chk("third pointer", 16'h1234, ptr_addr_q);
		$display("test pointers done");
		pulse_flag(4'h6);
		do_op(3'h6);
		wait_pulse(8, 0, n);
		chk("no take at enable boundary", 16'h0000, n[15:0]);
		do_op(3'h0);
		expect_pulse("entry cycles", 0, 4);
		chk("winning source", 16'h0001, {8'h00, vec_idx_q});
		chk("global enable after take", 16'h0000, {15'h0, status_register_q[7]});
		chk("sp after entry", 16'h017e, sp_q);
		do_op(3'h5);
		expect_pulse("return cycles", 1, 4);
		#1;
		chk("global enable after return", 16'h0001, {15'h0, status_register_q[7]});
		chk("sp after return", 16'h0180, sp_q);
		do_op(3'h0);
		expect_pulse("second entry", 0, 4);
		chk("remaining source", 16'h0002, {8'h00, vec_idx_q});
		do_op(3'h5);
		expect_pulse("second return", 1, 4);
		$display("test entry and return done");
		@(posedge ref_clk);
		sleeping <= 1'b1;
		pulse_flag(4'h8);
		do_op(3'h0);
		expect_pulse("entry from sleep", 0, 8);
		@(posedge ref_clk);
		sleeping <= 1'b0;
		do_op(3'h5);
		expect_pulse("return after sleep", 1, 4);
		$display("test sleep done");
		@(posedge ref_clk);
		flag_evt <= 4'h1;
		issue    <= 1'b1;
		issue_op <= 3'h7;
		@(posedge ref_clk);
		flag_evt <= 4'h0;
		issue    <= 1'b0;
		wait_pulse(10, 0, n);
		chk("no take at disable", 16'h0000, n[15:0]);
		chk("global enable after disable", 16'h0000, {15'h0, status_register_q[7]});
		$display("test disable done");
		@(posedge ref_clk);
		flag_w1c <= 4'h1;
		src_en   <= 6'h37;
		@(posedge ref_clk);
		flag_w1c <= 4'h0;
		pulse_flag(4'h8);
		do_op(3'h6);
		do_op(3'h0);
		wait_pulse(10, 0, n);
		chk("no take after clear or disabled source", 16'h0000, n[15:0]);
		$display("test clear and source enable done");
		@(posedge ref_clk);
		src_en <= 6'h3f;
		do_op(3'h0);
		expect_pulse("held flag entry", 0, 4);
		chk("held flag source", 16'h0003, {8'h00, vec_idx_q});
		@(posedge ref_clk);
		alu_we    <= 1'b1;
		alu_flags <= 7'h55;
		@(posedge ref_clk);
		alu_we    <= 1'b0;
		level_req <= 2'h1;
		#1;
		chk("status after alu write", 16'h0055, {8'h00, status_register_q});
		@(posedge ref_clk);
		level_req <= 2'h0;
		do_op(3'h5);
		expect_pulse("return after held flag", 1, 4);
		chk("status kept over entry and return", 16'h00d5, {8'h00, status_register_q});
		do_op(3'h0);
		wait_pulse(10, 0, n);
		chk("vanished level not taken", 16'h0000, n[15:0]);
		@(posedge ref_clk);
		level_req <= 2'h2;
		pulse_flag(4'h1);
		do_op(3'h0);
		expect_pulse("flag zero over level", 0, 4);
		chk("request zero first", 16'h0000, {8'h00, vec_idx_q});
		do_op(3'h5);
		expect_pulse("return before level", 1, 4);
		do_op(3'h0);
		expect_pulse("held level entry", 0, 4);
		chk("level source", 16'h0005, {8'h00, vec_idx_q});
		$display("test held flag, status and level done");
		stop_test();
	end
endmodule : tb
